/* ppio_pkg.sv */
// Constants, register map and field layout for the parallel port pin block.
// Assumes one 40 MHz clock and an AXI4-Lite master on the register side.
//
// Notes on behaviour
// - Pins grouped: data 8, control 4, status 5.
// - Data output mode: 12 outputs, 5 inputs.
// - Data input mode: 4 outputs, 13 inputs.
// - Bidirectional control mode: 12 outputs, 9 inputs.
// - Direction fixed after install; three modes only.
// - Up to eight ports, numbered from zero.
// - Location below sixteen is a port index.
// - No direction keyword means data output.
// - Missing port location flags configuration error.
// - Control pins driven always; sampled in bidirectional mode.
// - Status pins always inputs.
// - Data pins inputs only in input mode.
// - Each input gives true and inverted copies.
// - Per-output polarity flag inverts the pin.
// - Read strobe samples inputs, one or all ports.
// - Write strobe drives inverted outputs, one or all.
// - Reset strobe clears selected pins after delay.
// - Auto-clear select affects only output pins.
// - Idle bidirectional control pin reads one (here always driven, so it reads its written level, zero after reset).
package ppio_pkg;
    localparam int NPORT = 8;
    localparam int NDATA = 8;
    localparam int NCTRL = 4;
    localparam int NSTAT = 5;
    localparam int NOUT = NDATA + NCTRL;
    localparam int NIN = NDATA + NCTRL + NSTAT;
    localparam int CLK_PERIOD_NS = 25;
    localparam logic [3:0] INDEX_LIMIT = 4'hF;
    // Register byte offsets.
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_STROBE = 8'h08;
    localparam logic [7:0] REG_PORTSEL = 8'h0C;
    localparam logic [7:0] REG_OUTVAL = 8'h10;
    localparam logic [7:0] REG_INVERT = 8'h14;
    localparam logic [7:0] REG_CLRSEL = 8'h18;
    localparam logic [7:0] REG_RSTTIME = 8'h1C;
    localparam logic [7:0] REG_INTRUE = 8'h20;
    localparam logic [7:0] REG_INNOT = 8'h24;
    // Field positions.
    localparam int CFG_LOC_LSB = 0;
    localparam int CFG_LOC_W = 16;
    localparam int CFG_HASLOC = 16;
    localparam int CFG_DIR_LSB = 17;
    localparam int STB_READ = 0;
    localparam int STB_WRITE = 1;
    localparam int STB_RESET = 2;
    localparam int STB_ALL = 3;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [31:0] RESET_TIME_DEF = 32'h0000_0000;
    // Direction keyword as written by configuration software.
    typedef enum logic [1:0] {
        DIR_NONE = 2'b00,
        DIR_OUT = 2'b01,
        DIR_IN = 2'b11,
        DIR_X = 2'b10
    } dir_type;
endpackage : ppio_pkg

/* ppio_top.sv */
// Parallel port pin logic for eight ports, each with data, control and
// status groups. Assumes an AXI4-Lite master and synchronous pin inputs
// only after two flip-flops.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module ppio_top
    import ppio_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [NPORT*NDATA-1:0] DATA_IN,
    output logic [NPORT*NDATA-1:0] DATA_OUT,
    output logic [NPORT*NDATA-1:0] DATA_OE,
    input wire logic [NPORT*NCTRL-1:0] CTRL_IN,
    output logic [NPORT*NCTRL-1:0] CTRL_OUT,
    output logic [NPORT*NCTRL-1:0] CTRL_OE,
    input wire logic [NPORT*NSTAT-1:0] STAT_IN,
    output logic CFG_ERROR
);

    // ------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------
    logic [31:0] config_r [NPORT];
    logic [NOUT-1:0] outval_r [NPORT];
    logic [NOUT-1:0] invert_r [NPORT];
    logic [NOUT-1:0] clrsel_r [NPORT];
    logic [31:0] rsttime_r [NPORT];
    logic [NIN-1:0] in_true_r [NPORT];
    logic [NIN-1:0] in_not_r [NPORT];
    logic [31:0] wr_stamp_r [NPORT];
    logic [NPORT-1:0] installed_r;
    logic [NPORT-1:0] clr_pend_r;
    logic [NPORT-1:0] loc_err_r;
    logic [2:0] portsel_r;
    logic [31:0] ns_count_r;
    logic [NIN-1:0] sync1_r [NPORT];
    logic [NIN-1:0] sync2_r [NPORT];
    logic [NOUT-1:0] pin_r [NPORT];
    logic [NPORT*NDATA-1:0] data_out_nxt;
    logic [NPORT*NDATA-1:0] data_oe_nxt;
    logic [NPORT*NCTRL-1:0] ctrl_out_nxt;

    // Effective direction; missing keyword means data output.
    function automatic dir_type port_dir(input logic [31:0] cfg);
        dir_type d;
        d = dir_type'(cfg[CFG_DIR_LSB +: 2]);
        if (d == DIR_NONE) begin
            d = DIR_OUT;
        end
        return d;
    endfunction : port_dir

    // ------------------------------------------------------------
    // AXI4-Lite slave.
    // ------------------------------------------------------------
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_go;
    logic [31:0] wmask;
    logic [2:0] wsel;

    assign wr_go = aw_hold_r && w_hold_r && !S_AXI_BVALID;
    assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    assign wsel = portsel_r;

    // Address and data are caught independently, in either order.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= !aw_hold_r && !S_AXI_AWREADY && !S_AXI_BVALID;
            S_AXI_WREADY <= !w_hold_r && !S_AXI_WREADY && !S_AXI_BVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_r <= 1'b1;
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (awaddr_r <= REG_INNOT) ? RESP_OKAY : RESP_SLVERR;
                S_AXI_AWREADY <= 1'b0;
                S_AXI_WREADY <= 1'b0;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Read channel: one cycle from address to data.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= RESP_OKAY;
                case (S_AXI_ARADDR)
                    REG_CONFIG: S_AXI_RDATA <= config_r[portsel_r];
                    REG_STATUS: S_AXI_RDATA <= {6'h00, loc_err_r, clr_pend_r, installed_r, CFG_ERROR, 1'b0};
                    REG_STROBE: S_AXI_RDATA <= 32'h0000_0000;
                    REG_PORTSEL: S_AXI_RDATA <= {29'h0000_0000, portsel_r};
                    REG_OUTVAL: S_AXI_RDATA <= {20'h00000, outval_r[portsel_r]};
                    REG_INVERT: S_AXI_RDATA <= {20'h00000, invert_r[portsel_r]};
                    REG_CLRSEL: S_AXI_RDATA <= {20'h00000, clrsel_r[portsel_r]};
                    REG_RSTTIME: S_AXI_RDATA <= rsttime_r[portsel_r];
                    REG_INTRUE: S_AXI_RDATA <= {15'h0000, in_true_r[portsel_r]};
                    REG_INNOT: S_AXI_RDATA <= {15'h0000, in_not_r[portsel_r]};
                    default: begin
                        S_AXI_RDATA <= 32'h0000_0000;
                        S_AXI_RRESP <= RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration and strobes.
    // ------------------------------------------------------------
    logic wr_strobe;
    logic [3:0] stb;
    assign wr_strobe = wr_go && (awaddr_r == REG_STROBE) && wstrb_r[0];
    assign stb = wr_strobe ? wdata_r[3:0] : 4'h0;

    // A configuration write is taken once per port; later writes are
    // ignored so the direction cannot flip under running hardware.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int p = 0; p < NPORT; p++) begin
                config_r[p] <= 32'h0000_0000;
                outval_r[p] <= '0;
                invert_r[p] <= '0;
                clrsel_r[p] <= '0;
                rsttime_r[p] <= RESET_TIME_DEF;
            end
            installed_r <= '0;
            loc_err_r <= '0;
            portsel_r <= 3'h0;
        end else if (wr_go) begin
            case (awaddr_r)
                REG_CONFIG: begin
                    if (!installed_r[wsel]) begin
                        config_r[wsel] <= wdata_r & wmask;
                        installed_r[wsel] <= 1'b1;
                        loc_err_r[wsel] <= !wdata_r[CFG_HASLOC];
                    end
                end
                REG_PORTSEL: portsel_r <= wdata_r[2:0];
                REG_OUTVAL: outval_r[wsel] <= wdata_r[NOUT-1:0];
                REG_INVERT: invert_r[wsel] <= wdata_r[NOUT-1:0];
                REG_CLRSEL: clrsel_r[wsel] <= wdata_r[NOUT-1:0];
                REG_RSTTIME: rsttime_r[wsel] <= (rsttime_r[wsel] & ~wmask) | (wdata_r & wmask);
                default: ;
            endcase
        end
    end

    // Location error: some installed port's configuration gave no location.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            CFG_ERROR <= 1'b0;
        end else begin
            CFG_ERROR <= |loc_err_r;
        end
    end

    // Index form of the location; only informative, the port slot is fixed.
    logic [NPORT-1:0] loc_is_index;
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            loc_is_index[p] = config_r[p][CFG_LOC_LSB +: CFG_LOC_W] <= 16'(INDEX_LIMIT);
        end
    end

    // ------------------------------------------------------------
    // Nanosecond time base and inputs.
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            ns_count_r <= 32'h0000_0000;
        end else begin
            ns_count_r <= ns_count_r + 32'(CLK_PERIOD_NS);
        end
    end

    // Two-stage synchronisers; the first stage feeds only the second.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int p = 0; p < NPORT; p++) begin
                sync1_r[p] <= '0;
                sync2_r[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                sync1_r[p] <= {STAT_IN[p*NSTAT +: NSTAT], CTRL_IN[p*NCTRL +: NCTRL], DATA_IN[p*NDATA +: NDATA]};
                sync2_r[p] <= sync1_r[p];
            end
        end
    end

    // Read strobe: capture inputs per mode; unused inputs read low/high.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int p = 0; p < NPORT; p++) begin
                in_true_r[p] <= '0;
                in_not_r[p] <= '1;
            end
        end else if (stb[STB_READ]) begin
            for (int p = 0; p < NPORT; p++) begin
                if (stb[STB_ALL] || p == int'(portsel_r)) begin
                    logic [NIN-1:0] s;
                    s = sync2_r[p] & {{NSTAT{1'b1}},
                        {NCTRL{port_dir(config_r[p]) == DIR_X}},
                        {NDATA{port_dir(config_r[p]) == DIR_IN}}};
                    in_true_r[p] <= s;
                    in_not_r[p] <= ~s;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Output pins: write, timed auto-clear, and polarity.
    // ------------------------------------------------------------
    // Reset strobes before the delay has run simply wait for a later one.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int p = 0; p < NPORT; p++) begin
                pin_r[p] <= '0;
                wr_stamp_r[p] <= 32'h0000_0000;
            end
            clr_pend_r <= '0;
        end else if (wr_go && awaddr_r == REG_INVERT && !installed_r[wsel]) begin
            pin_r[wsel] <= wdata_r[NOUT-1:0];
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                if (stb[STB_ALL] || p == int'(portsel_r)) begin
                    if (stb[STB_WRITE]) begin
                        pin_r[p] <= outval_r[p] ^ invert_r[p];
                        wr_stamp_r[p] <= ns_count_r;
                        clr_pend_r[p] <= 1'b1;
                    end else if (stb[STB_RESET] && clr_pend_r[p]
                                 && (ns_count_r - wr_stamp_r[p]) >= rsttime_r[p]) begin
                        for (int b = 0; b < NOUT; b++) begin
                            if (clrsel_r[p][b] && (b >= NDATA || port_dir(config_r[p]) != DIR_IN)) begin
                                pin_r[p][b] <= invert_r[p][b];
                            end
                        end
                        clr_pend_r[p] <= 1'b0;
                    end
                end
            end
        end
    end

    // Data pins drive only outside input mode; control pins always drive.
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            data_out_nxt[p*NDATA +: NDATA] = pin_r[p][NDATA-1:0];
            data_oe_nxt[p*NDATA +: NDATA] = {NDATA{port_dir(config_r[p]) != DIR_IN}};
            ctrl_out_nxt[p*NCTRL +: NCTRL] = pin_r[p][NOUT-1:NDATA];
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            DATA_OUT <= '0;
            DATA_OE <= '0;
            CTRL_OUT <= '0;
            CTRL_OE <= '0;
        end else begin
            DATA_OUT <= data_out_nxt;
            DATA_OE <= data_oe_nxt;
            CTRL_OUT <= ctrl_out_nxt;
            CTRL_OE <= '1;
        end
    end

endmodule : ppio_top

/* ppio_checker.sv */
// Concurrent checks on the pins and bus handshakes of the parallel port pin block.
// Assumes it is bound into ppio_top and sees only that module's ports.
`timescale 1ns/1ps
module ppio_checker
    import ppio_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [NPORT*NDATA-1:0] DATA_OUT,
    input wire logic [NPORT*NDATA-1:0] DATA_OE,
    input wire logic [NPORT*NCTRL-1:0] CTRL_OUT,
    input wire logic [NPORT*NCTRL-1:0] CTRL_OE
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_B);
    // Cycles since the last write beat; strobes only follow one.
    logic [3:0] since_w_r;
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            since_w_r <= 4'hF;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            since_w_r <= 4'h0;
        end else if (since_w_r != 4'hF) begin
            since_w_r <= since_w_r + 4'h1;
        end
    end
    property p_ctrl_oe;
        $past(RST_B) |-> (&CTRL_OE);
    endproperty
    a_ctrl_oe: assert property (p_ctrl_oe)
        else $error("control pin enables not all high");
    for (genvar p = 0; p < NPORT; p++) begin : g_oe
        property p_data_oe_group;
            (DATA_OE[p*8+:8] == 8'h00) || (DATA_OE[p*8+:8] == 8'hFF);
        endproperty
        a_data_oe_group: assert property (p_data_oe_group)
            else $error("data pin enables split within one port");
    end
    property p_out_change;
        $changed({DATA_OUT, CTRL_OUT}) |-> since_w_r <= 4'h4;
    endproperty
    a_out_change: assert property (p_out_change)
        else $error("output pins moved without a strobe");
    property p_bvalid_hold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold)
        else $error("write response dropped early");
    property p_rvalid_hold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold)
        else $error("read answer not held");
    property p_read_answer;
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read answer late");
    property p_read_error;
        S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR > REG_INNOT) |=> S_AXI_RRESP == RESP_SLVERR;
    endproperty
    a_read_error: assert property (p_read_error)
        else $error("unmapped read not refused");
    property p_write_answer;
        $rose(S_AXI_BVALID) |-> $past(S_AXI_WREADY) || $past(S_AXI_WREADY, 2);
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write response without data beat");
    property p_awready_pulse;
        S_AXI_AWREADY |=> !S_AXI_AWREADY;
    endproperty
    a_awready_pulse: assert property (p_awready_pulse)
        else $error("address ready held too long");
endmodule : ppio_checker

bind ppio_top ppio_checker i_ppio_checker (
    .MCLK, .RST_B, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
    .S_AXI_RREADY, .DATA_OUT, .DATA_OE, .CTRL_OUT, .CTRL_OE
);

/* ppio_pins_model.sv */
// Connector-side model of the machine hardware on the port pins.
// Assumes the bench commands the levels the machine presents.
`timescale 1ns/1ps
module ppio_pins_model
    import ppio_pkg::*;
(
    input wire logic clk,
    input wire logic [NPORT*NDATA-1:0] data_out,
    input wire logic [NPORT*NDATA-1:0] data_oe,
    input wire logic [NPORT*NCTRL-1:0] ctrl_out,
    input wire logic [NPORT*NCTRL-1:0] ctrl_oe,
    input wire logic [NPORT*NDATA-1:0] ext_data,
    input wire logic [NPORT-1:0] ext_drive,
    input wire logic [NPORT*NCTRL-1:0] pull_low,
    input wire logic [NPORT*NSTAT-1:0] ext_stat,
    output logic [NPORT*NDATA-1:0] data_in,
    output logic [NPORT*NCTRL-1:0] ctrl_in,
    output logic [NPORT*NSTAT-1:0] stat_in
);
    // A floating data line toggles, so a stale level never passes as read data.
    logic wander_r = 1'b0;
    always @(posedge clk) begin
        wander_r <= ~wander_r;
    end
    // Data pins: the port wins when it drives, else the machine or nothing at all.
    always_comb begin
        for (int i = 0; i < NPORT*NDATA; i++) begin
            data_in[i] = data_oe[i] ? data_out[i] : (ext_drive[i/NDATA] ? ext_data[i] : wander_r ^ i[0]);
        end
    end
    // Control lines are open collector with a pull-up: the machine may only pull them low.
    assign ctrl_in = (ctrl_out | ~ctrl_oe) & ~pull_low;
    assign stat_in = ext_stat;
endmodule : ppio_pins_model

/* testbench.sv */
// Self-checking bench for the parallel port pin block, driven over its register bus.
// Assumes the pin model on the connector side and the bound checker.
`timescale 1ns/1ps
module testbench
    import ppio_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] cfg_word [5] = '{32'h0001_0003, 32'h0007_0378, 32'h0005_0002, 32'h0002_0000, 32'h0003_0378};
    logic [63:0] x_data = 64'h0;
    logic [7:0] x_drv = 8'h00;
    logic [31:0] pull = 32'h0;
    logic [39:0] stat = 40'h0;
    logic awready, wready, bvalid, arready, rvalid, cfg_err;
    logic [1:0] bresp, rresp, last_bresp, last_rresp;
    logic [31:0] rdata, last_rdata, c_in, c_out, c_oe, exp0;
    logic [63:0] d_in, d_out, d_oe;
    logic [39:0] s_in;
    logic [31:0] nxt [3];
    logic [31:0] v;
    int num_errors = 0;
    int n_checks = 0;
    always #12.5 mclk = ~mclk;
    ppio_top i_ppio_top (
        .MCLK(mclk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .DATA_IN(d_in), .DATA_OUT(d_out), .DATA_OE(d_oe),
        .CTRL_IN(c_in), .CTRL_OUT(c_out), .CTRL_OE(c_oe), .STAT_IN(s_in), .CFG_ERROR(cfg_err));
    ppio_pins_model i_ppio_pins_model (
        .clk(mclk), .data_out(d_out), .data_oe(d_oe), .ctrl_out(c_out), .ctrl_oe(c_oe), .ext_data(x_data),
        .ext_drive(x_drv), .pull_low(pull), .ext_stat(stat), .data_in(d_in), .ctrl_in(c_in), .stat_in(s_in));
    // ----------------------------------------
    // Bus tasks, comparison and expectations
    // ----------------------------------------
    // Address and data go out together; each drops at its own ready.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        last_bresp = bresp;
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a);
        @(posedge mclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        last_rdata = rdata;
        last_rresp = rresp;
    endtask : axi_read
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    function automatic logic [31:0] pins(input int p);
        return {20'h0, c_out[p*4+:4], d_out[p*8+:8]};
    endfunction : pins
    function automatic logic [31:0] drive_val(input logic [31:0] val, input logic [31:0] inv);
        return (val ^ inv) & 32'h0000_0FFF;
    endfunction : drive_val
    function automatic logic [31:0] clear_val(input logic [31:0] now, input logic [31:0] sel, input logic [31:0] inv);
        return (now & ~sel) | (inv & sel);
    endfunction : clear_val
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(18));
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        axi_read(8'h28);
        check("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, last_rresp});
        axi_write(8'h30, 32'h0);
        check("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, last_bresp});
        // Out, in, open-collector and unlocated ports, then a refused rewrite.
        for (int k = 0; k < 5; k++) begin
            axi_write(REG_PORTSEL, 32'(k == 4 ? 1 : k));
            axi_write(REG_CONFIG, cfg_word[k]);
        end
        repeat (4) @(posedge mclk);
        check("oe out port", 32'hFF, {24'h0, d_oe[7:0]});
        check("oe in port", 32'h00, {24'h0, d_oe[15:8]});
        check("oe x port", 32'hFF, {24'h0, d_oe[23:16]});
        check("ctrl oe", 32'hFFFF, {16'h0, c_oe[15:0]});
        axi_read(REG_STATUS);
        check("status", 32'h0020_003E, last_rdata & 32'h03FC_03FF);
        check("cfg error pin", 32'h1, {31'h0, cfg_err});
        $display("Test configuration done");
        // Random values on ports 0 and 2; even rounds strobe port 2, odd rounds all.
        exp0 = 32'h0;
        for (int i = 0; i < 12; i++) begin
            for (int p = 0; p < 3; p += 2) begin
                v = $urandom() & 32'h0000_0FFF;
                nxt[p] = $urandom() & 32'h0000_0FFF;
                axi_write(REG_PORTSEL, 32'(p));
                axi_write(REG_INVERT, nxt[p]);
                axi_write(REG_OUTVAL, v);
                nxt[p] = drive_val(v, nxt[p]);
            end
            axi_write(REG_STROBE, i[0] ? 32'h0000_000A : 32'h0000_0002);
            repeat (4) @(posedge mclk);
            if (i[0]) begin
                exp0 = nxt[0];
            end
            check("pins port 0", exp0, pins(0));
            check("pins port 2", nxt[2], pins(2));
        end
        $display("Test write strobes done");
        // Port 2 control lines high; only the machine pulls them down.
        axi_write(REG_INVERT, 32'h0);
        axi_write(REG_OUTVAL, 32'h0000_0F00);
        axi_write(REG_STROBE, 32'h0000_0002);
        x_drv <= 8'hFF;
        for (int i = 0; i < 8; i++) begin
            x_data <= {$urandom(), $urandom()};
            stat <= 40'({$urandom(), $urandom()});
            pull <= (i == 0) ? 32'h0 : $urandom();
            repeat (4) @(posedge mclk);
            axi_write(REG_PORTSEL, 32'h1);
            axi_write(REG_STROBE, i[0] ? 32'h0000_0009 : 32'h0000_0001);
            v = {15'h0, stat[9:5], 4'h0, x_data[15:8]};
            axi_read(REG_INTRUE);
            check("true copy p1", v, last_rdata & 32'h1_F0FF);
            axi_read(REG_INNOT);
            check("inverted copy p1", ~v & 32'h1_F0FF, last_rdata & 32'h1_F0FF);
            if (i[0]) begin
                axi_write(REG_PORTSEL, 32'h2);
                axi_read(REG_INTRUE);
                check("true copy p2", {15'h0, stat[14:10], ~pull[11:8], 8'h0}, last_rdata & 32'h1_FF00);
            end
        end
        $display("Test read strobes done");
        // Auto-clear on port 0: an early reset strobe is ignored, a late one clears.
        axi_write(REG_PORTSEL, 32'h0);
        axi_write(REG_RSTTIME, 32'h0000_01F4);
        axi_write(REG_CLRSEL, 32'h0000_00FF);
        axi_write(REG_INVERT, 32'h0000_00A5);
        axi_write(REG_OUTVAL, 32'h0000_0F0F);
        axi_write(REG_STROBE, 32'h0000_0002);
        axi_write(REG_STROBE, 32'h0000_0004);
        repeat (4) @(posedge mclk);
        check("early clear", drive_val(32'hF0F, 32'h0A5), pins(0));
        repeat (30) @(posedge mclk);
        axi_write(REG_STROBE, 32'h0000_0004);
        repeat (4) @(posedge mclk);
        check("auto clear", clear_val(drive_val(32'hF0F, 32'h0A5), 32'h0FF, 32'h0A5), pins(0));
        $display("Test auto clear done");
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        check("pins after reset", 32'h0, pins(0));
        $display("Test mid-run reset done");
        stop_test();
    end
    // The whole run needs well under a thousand cycles; this span is 30000 cycles.
    initial begin
        #(25 * 30000);
        num_errors++;
        stop_test();
    end
endmodule : testbench
